/* verilog/ddp_cfg.svh */
`ifndef DDP_CFG_SVH
`define DDP_CFG_SVH

// Register byte addresses in the core's register space
`define DDP_ADDR_PTR_LO   8'h82
`define DDP_ADDR_PTR_HI   8'h83
`define DDP_ADDR_CTRL     8'h85
`define DDP_ADDR_MODE     8'h86

// Control register fields
`define DDP_CTRL_SEL_BIT  0
`define DDP_CTRL_SWAP_BIT 6
`define DDP_CTRL_RESET    8'h00

// Step mode register fields
`define DDP_MODE_P0_LSB   0
`define DDP_MODE_P1_LSB   2
`define DDP_MODE_RESET    8'h00

// Step mode codes
`define DDP_STEP_HOLD     2'h0
`define DDP_STEP_RSVD     2'h1
`define DDP_STEP_INC      2'h2
`define DDP_STEP_DEC      2'h3

// Answer to a read of an address this block does not own
`define DDP_RD_UNMAPPED   8'h00

`endif

/* verilog/ddp_pkg.sv */
`default_nettype none

package ddp_pkg;

    // Number of pointers, selected and background
    localparam int DDP_NUM_PTR = 2;

    // Whole state of the pointer unit
    typedef struct packed {
        logic [15:0] ptrOne;     // Pointer one value
        logic [15:0] ptrZero;    // Pointer zero value
        logic        ptrSelect;  // 1 selects pointer one
        logic        autoSwap;   // Toggle selection after each move
        logic [3:0]  stepMode;   // Two step fields, zero in low bits
        logic [7:0]  rdData;     // Registered read answer
        logic [15:0] activePtr;  // Copy of the selected pointer
    } ddp_state_t;

endpackage

`default_nettype wire

/* verilog/ddp_stepper.sv */
`default_nettype none
`include "ddp_cfg.svh"

// Post-move step of one pointer; wraps at 16 bits, reserved code holds
module ddp_stepper
    import ddp_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic [WIDTH-1:0] curVal,
    input  wire logic [1:0]       mode,
    input  wire logic             stepEn,
    output logic      [WIDTH-1:0] nextVal
);

    // Width must be at least one bit
    if (WIDTH < 1) begin : g_bad_width
        $error("ddp_stepper: WIDTH must be positive");
    end

    // Select the stepped value
    always_comb begin
        nextVal = curVal;
        if (stepEn) begin
            unique case (mode)
                `DDP_STEP_INC: nextVal = curVal + WIDTH'(1);
                `DDP_STEP_DEC: nextVal = curVal - WIDTH'(1);
                default:       nextVal = curVal;
            endcase
        end
    end

endmodule

`default_nettype wire

/* verilog/ddp_unit.sv */
// How it works
// - Reset selects pointer zero at 82h/83h.
// - Select one maps pointer one; other hidden.
// - Auto swap toggles select after each move.
// - Two-bit modes: hold, reserved, increment, decrement.
// - Only selected pointer steps.
// - Only external data moves step or toggle.
// - Move uses current value, then steps, toggles.
// - Control and mode registers reset to zero.
`default_nettype none
`include "ddp_cfg.svh"

module ddp_unit
    import ddp_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrRdEn,
    input  wire logic       xdmDone,
    output logic      [7:0] sfrRdData,
    output logic      [15:0] xdmAddr
);

    ddp_state_t stReg;                  // Registered state
    ddp_state_t stNext;                 // Next state
    logic [15:0] ptrCur  [DDP_NUM_PTR]; // Current pointer values
    logic [15:0] ptrStep [DDP_NUM_PTR]; // Values after optional step
    logic [1:0]  ptrMode [DDP_NUM_PTR]; // Step mode of each pointer
    logic        ptrEn   [DDP_NUM_PTR]; // Step enable per pointer
    logic        wrLo;                  // Write to low pointer byte
    logic        wrHi;                  // Write to high pointer byte
    logic        wrCtrl;                // Write to control register
    logic        wrMode;                // Write to mode register

    // Checks below run on the core clock; all but the reset check are quiet during reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Unit is built for exactly two pointers
    if (DDP_NUM_PTR != 2) begin : g_bad_count
        $error("ddp_unit: exactly two pointers are supported");
    end

    // Write decodes
    assign wrLo   = sfrWrEn && (sfrAddr == `DDP_ADDR_PTR_LO);
    assign wrHi   = sfrWrEn && (sfrAddr == `DDP_ADDR_PTR_HI);
    assign wrCtrl = sfrWrEn && (sfrAddr == `DDP_ADDR_CTRL);
    assign wrMode = sfrWrEn && (sfrAddr == `DDP_ADDR_MODE);

    assign ptrCur[0] = stReg.ptrZero;
    assign ptrCur[1] = stReg.ptrOne;

    // One stepper per pointer
    for (genvar i = 0; i < DDP_NUM_PTR; i++) begin : g_ptr
        // Mode field of this pointer
        assign ptrMode[i] = stReg.stepMode[2*i +: 2];
        // Only a move steps, and only the selected pointer
        assign ptrEn[i] = xdmDone && (stReg.ptrSelect == 1'(i));
        ddp_stepper #(
            .WIDTH (16)
        ) u_step (
            .curVal  (ptrCur[i]),
            .mode    (ptrMode[i]),
            .stepEn  (ptrEn[i]),
            .nextVal (ptrStep[i])
        );
    end

    // Next state: move effects first, register writes override
    always_comb begin
        stNext = stReg;
        // Step after the move has used the old value
        stNext.ptrZero = ptrStep[0];
        stNext.ptrOne  = ptrStep[1];
        // Toggle selection after a move when auto swap is on
        if (xdmDone && stReg.autoSwap) begin
            stNext.ptrSelect = ~stReg.ptrSelect;
        end
        // Pointer window reaches only the selected pointer
        if (wrLo) begin
            if (stReg.ptrSelect) begin
                stNext.ptrOne[7:0] = sfrWrData;
            end else begin
                stNext.ptrZero[7:0] = sfrWrData;
            end
        end
        if (wrHi) begin
            if (stReg.ptrSelect) begin
                stNext.ptrOne[15:8] = sfrWrData;
            end else begin
                stNext.ptrZero[15:8] = sfrWrData;
            end
        end
        // Firmware writes of control and mode
        if (wrCtrl) begin
            stNext.ptrSelect = sfrWrData[`DDP_CTRL_SEL_BIT];
            stNext.autoSwap  = sfrWrData[`DDP_CTRL_SWAP_BIT];
        end
        if (wrMode) begin
            stNext.stepMode = sfrWrData[3:0];
        end
        // Read answer, reserved bits as zero
        if (sfrRdEn) begin
            unique case (sfrAddr)
                `DDP_ADDR_PTR_LO: stNext.rdData = stReg.activePtr[7:0];
                `DDP_ADDR_PTR_HI: stNext.rdData = stReg.activePtr[15:8];
                `DDP_ADDR_CTRL: begin
                    stNext.rdData = 8'h00;
                    stNext.rdData[`DDP_CTRL_SEL_BIT]  = stReg.ptrSelect;
                    stNext.rdData[`DDP_CTRL_SWAP_BIT] = stReg.autoSwap;
                end
                `DDP_ADDR_MODE: stNext.rdData = {4'h0, stReg.stepMode};
                default:        stNext.rdData = `DDP_RD_UNMAPPED;
            endcase
        end
        // Address copy follows the selected pointer
        stNext.activePtr = stNext.ptrSelect ? stNext.ptrOne
                                            : stNext.ptrZero;
    end

    // State register, synchronous reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stReg <= '0;
        end else begin
            stReg <= stNext;
        end
    end

    // Outputs straight from flops
    assign sfrRdData = stReg.rdData;
    assign xdmAddr   = stReg.activePtr;

    logic ptrWr;  // Any pointer byte write
    assign ptrWr = wrLo || wrHi;

    // Reset leaves pointer zero selected and registers zero
    property p_reset_clear;
        // Own disable; the default one would mute this check entirely
        @(posedge core_clk) disable iff (1'b0)
            rst |=> (!stReg.ptrSelect && !stReg.autoSwap
            && stReg.stepMode == 4'h0);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("control state not cleared by reset");

    // Low window byte reads the selected pointer
    property p_read_lo;
        sfrRdEn && sfrAddr == `DDP_ADDR_PTR_LO
            |=> sfrRdData == ($past(stReg.ptrSelect) ?
                $past(stReg.ptrOne[7:0]) : $past(stReg.ptrZero[7:0]));
    endproperty
    a_read_lo: assert property (p_read_lo)
        else $error("window read returned wrong pointer");

    // Auto swap flips the selection after a move
    property p_toggle;
        xdmDone && stReg.autoSwap && !wrCtrl
            |=> stReg.ptrSelect != $past(stReg.ptrSelect);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("selection did not toggle after move");

    // Without auto swap a move keeps the selection
    property p_no_toggle;
        xdmDone && !stReg.autoSwap && !wrCtrl |=> $stable(stReg.ptrSelect);
    endproperty
    a_no_toggle: assert property (p_no_toggle)
        else $error("selection changed without auto swap");

    // Increment of pointer zero
    property p_inc_zero;
        xdmDone && !stReg.ptrSelect && !ptrWr
            && stReg.stepMode[1:0] == `DDP_STEP_INC
            |=> stReg.ptrZero == $past(stReg.ptrZero) + 16'h0001;
    endproperty
    a_inc_zero: assert property (p_inc_zero)
        else $error("pointer zero did not increment");

    // Decrement of pointer one
    property p_dec_one;
        xdmDone && stReg.ptrSelect && !ptrWr
            && stReg.stepMode[3:2] == `DDP_STEP_DEC
            |=> stReg.ptrOne == $past(stReg.ptrOne) - 16'h0001;
    endproperty
    a_dec_one: assert property (p_dec_one)
        else $error("pointer one did not decrement");

    // Reserved code holds the pointer
    property p_reserved;
        xdmDone && !stReg.ptrSelect && !ptrWr
            && stReg.stepMode[1:0] == `DDP_STEP_RSVD
            |=> $stable(stReg.ptrZero);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved mode changed pointer");

    // Background pointer one never steps while pointer zero is selected
    property p_background;
        xdmDone && !stReg.ptrSelect |=> $stable(stReg.ptrOne);
    endproperty
    a_background: assert property (p_background)
        else $error("background pointer changed");

    // No move and no write leaves pointers and selection alone
    property p_idle;
        !xdmDone && !sfrWrEn |=> $stable(stReg.ptrZero)
            && $stable(stReg.ptrOne) && $stable(stReg.ptrSelect);
    endproperty
    a_idle: assert property (p_idle)
        else $error("pointer state changed without a move");

    // Address out is the selected pointer, pre-step during the move
    property p_addr_match;
        xdmAddr == (stReg.ptrSelect ? stReg.ptrOne : stReg.ptrZero);
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("move address differs from selected pointer");

    // Main scenarios
    c_swap_move: cover property (xdmDone && stReg.autoSwap);
    c_inc_wrap: cover property (xdmDone && stReg.ptrZero == 16'hFFFF
        && !stReg.ptrSelect && stReg.stepMode[1:0] == `DDP_STEP_INC);
    c_dec_one: cover property (xdmDone && stReg.ptrSelect
        && stReg.stepMode[3:2] == `DDP_STEP_DEC);
    c_write_move: cover property (xdmDone && wrLo);

endmodule

`default_nettype wire

/* verif/ddp_core_model.sv */
`default_nettype none

// Core side: register accesses and move strobes, driven at falling edge
module ddp_core_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] sfrRdData,
    output var  logic [7:0] sfrAddr,
    output var  logic       sfrWrEn,
    output var  logic [7:0] sfrWrData,
    output var  logic       sfrRdEn,
    output var  logic       xdmDone
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet bus at time zero
    initial begin
        sfrAddr   = 8'h00;
        sfrWrEn   = 1'b0;
        sfrWrData = 8'h00;
        sfrRdEn   = 1'b0;
        xdmDone   = 1'b0;
    end

    // Write strobe for one edge; lines scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfrAddr   = a;
        sfrWrData = d;
        sfrWrEn   = 1'b1;
        @(negedge core_clk);
        sfrWrEn   = 1'b0;
        sfrWrData = ~d;
        sfrAddr   = ~a;
    endtask

    // Read strobe for one edge; answer taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(negedge core_clk);
        sfrRdEn = 1'b0;
        sfrAddr = ~a;
        d       = sfrRdData;
    endtask

    // Move strobe raised; stays up until mvEnd
    task automatic mvStart();
        @(negedge core_clk);
        xdmDone = 1'b1;
    endtask

    // Move strobe dropped, called at a falling edge
    task automatic mvEnd();
        xdmDone = 1'b0;
    endtask
endmodule

`default_nettype wire

/* verif/ddp_unit_tb.sv */
`default_nettype none

module ddp_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk;    // Core clock
    logic        rst;         // Synchronous reset
    logic [7:0]  sfrAddr;     // Register address
    logic        sfrWrEn;     // Write strobe
    logic [7:0]  sfrWrData;   // Write data
    logic        sfrRdEn;     // Read strobe
    logic        xdmDone;     // Move completed
    logic [7:0]  sfrRdData;   // Read answer
    logic [15:0] xdmAddr;     // Selected pointer
    int          mismatches;  // Failed comparisons
    int          num_checks;  // All comparisons
    int          cycles;      // Timeout counter

    ddp_unit u_dut (.core_clk(core_clk), .rst(rst), .sfrAddr(sfrAddr),
        .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
        .xdmDone(xdmDone), .sfrRdData(sfrRdData), .xdmAddr(xdmAddr));

    ddp_core_model u_core (.core_clk(core_clk), .sfrRdData(sfrRdData),
        .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
        .sfrRdEn(sfrRdEn), .xdmDone(xdmDone));

    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Verdict and end of run
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end

    // Value compare
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register read compare
    task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_core.rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    // Pointer window load, low byte then high byte
    task automatic setPtr(input logic [15:0] v);
        u_core.wr(8'h82, v[7:0]);
        u_core.wr(8'h83, v[15:8]);
    endtask

    // Single move
    task automatic mv1();
        u_core.mvStart();
        @(negedge core_clk);
        u_core.mvEnd();
    endtask

    // Expected pointer after one step
    function automatic logic [15:0] stepOf(input logic [15:0] v,
                                           input logic [1:0]  m);
        return (m == 2'h2) ? v + 16'h1 : (m == 2'h3) ? v - 16'h1 : v;
    endfunction

    // Reset values; plain core with no stepping
    task automatic t_reset();
        chk(xdmAddr, 16'h0000);
        chkReg(8'h85, 8'h00);
        chkReg(8'h86, 8'h00);
        chkReg(8'h82, 8'h00);
        chkReg(8'h84, 8'h00);
        mv1();
        chk(xdmAddr, 16'h0000);
        chkReg(8'h85, 8'h00);
    endtask

    // Window follows select; hidden pointer kept
    task automatic t_select();
        setPtr(16'h1234);
        chk(xdmAddr, 16'h1234);
        chkReg(8'h83, 8'h12);
        u_core.wr(8'h85, 8'hFF);
        chkReg(8'h85, 8'h41);
        chk(xdmAddr, 16'h0000);
        setPtr(16'hABCD);
        chkReg(8'h82, 8'hCD);
        u_core.wr(8'h85, 8'h00);
        chk(xdmAddr, 16'h1234);
        chkReg(8'h83, 8'h12);
    endtask

    // Every mode code on both pointers, at both wrap edges
    task automatic t_modes();
        logic [15:0] st;
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 4; m++) begin
                for (int e = 0; e < 2; e++) begin
                    st = e ? 16'hFFFF : 16'h0000;
                    u_core.wr(8'h85, 8'(s));
                    setPtr(st);
                    u_core.wr(8'h86, 8'(m << (2 * s)));
                    mv1();
                    chk(xdmAddr, stepOf(st, 2'(m)));
                end
            end
        end
        u_core.wr(8'h85, 8'h01);
        setPtr(16'h5555);
        u_core.wr(8'h85, 8'h00);
        u_core.wr(8'h86, 8'h08);
        mv1();
        u_core.wr(8'h85, 8'h01);
        chk(xdmAddr, 16'h5555);
    endtask

    // Block copy: toggling, back-to-back moves, no stray steps
    task automatic t_swap();
        u_core.wr(8'h85, 8'h01);
        setPtr(16'h2000);
        u_core.wr(8'h85, 8'h40);
        setPtr(16'h1000);
        u_core.wr(8'h86, 8'h0A);
        repeat (5) @(negedge core_clk);
        chk(xdmAddr, 16'h1000);
        u_core.mvStart();
        chk(xdmAddr, 16'h1000);
        @(negedge core_clk);
        chk(xdmAddr, 16'h2000);
        @(negedge core_clk);
        chk(xdmAddr, 16'h1001);
        u_core.mvEnd();
        chkReg(8'h85, 8'h40);
        u_core.wr(8'h85, 8'h00);
        mv1();
        chk(xdmAddr, 16'h1002);
        chkReg(8'h85, 8'h00);
        u_core.wr(8'h85, 8'h01);
        chk(xdmAddr, 16'h2001);
    endtask

    // Reset in mid-run clears a busy unit
    task automatic t_rerst();
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        chk(xdmAddr, 16'h0000);
        chkReg(8'h85, 8'h00);
        chkReg(8'h86, 8'h00);
        chkReg(8'h82, 8'h00);
        chkReg(8'h83, 8'h00);
    endtask

    // Main sequence
    initial begin
        mismatches = 0;
        num_checks = 0;
        cycles     = 0;
        rst        = 1'b1;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_select();
        t_modes();
        t_swap();
        t_rerst();
        finish_test();
    end
endmodule

`default_nettype wire
